/* File: dep_stage.sv */
/*
  dep_stage: pick-up, angle and status logic of one directional residual
  stage, with an APB register file and a level interrupt.
  Assumes measurement channels on the same clock that pulse meas_valid
  with fresh magnitudes and angles (angles 0..3599 in 0.1 deg units).
*/
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dep_params.svh"
// Contract
// - forcing drives status to the chosen code
// - polarity picks voltage or its inverse
// - voltage source: auto, calculated, channel a/b
// - magnitude type only for measured inputs
// - current source: coarse, sensitive or calculated
// - release below 97 percent of threshold
// - pick-up when current exceeds its threshold
// - voltage threshold and angle area also checked
// - grounding mode selects the angle criterion
// - multi-criteria only in broad range mode
// - border angle splits broad range regions
// - grounded area half-width is programmable
// - grounded area rotated by programmable offset
// - compensated mode applies angle blinder
// - start only while block is inactive, or when a start code is forced
// - unearthed forward: current lags ninety degrees
// - static selections unaffected by setting group
// - angle needs one percent squelch on both

module dep_stage
  import dep_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        meas_valid,
  input  wire dep_mag_t    i_coarse_rms,
  input  wire dep_mag_t    i_coarse_true_rms_magnitude,
  input  wire dep_mag_t    i_coarse_pp,
  input  wire dep_mag_t    i_sens_rms,
  input  wire dep_mag_t    i_sens_true_rms_magnitude,
  input  wire dep_mag_t    i_sens_pp,
  input  wire dep_mag_t    i_calc,
  input  wire dep_mag_t    ang_coarse,
  input  wire dep_mag_t    ang_sens,
  input  wire dep_mag_t    ang_calc,
  input  wire dep_mag_t    u_calc,
  input  wire dep_mag_t    u_chan_a,
  input  wire dep_mag_t    u_chan_b,
  input  wire logic        u_calc_ok,
  input  wire dep_mag_t    uang_calc,
  input  wire dep_mag_t    uang_a,
  input  wire dep_mag_t    uang_b,
  input  wire logic        mcd_fault,
  input  wire logic [2:0]  group_sel,
  input  wire logic        block_pin,
  output var  logic        start,
  output var  logic        trip,
  output var  logic        blocked,
  output var  logic [2:0]  stage_status,
  output var  logic        pickup,
  output var  logic        irq
);

  localparam dep_ang_t DEG90  = `DEP_DEG90;
  localparam dep_ang_t DEG180 = `DEP_DEG180;
  localparam dep_ang_t DEG360 = `DEP_DEG360;

  logic [2:0]  force_code;
  logic        force_en;
  logic [1:0]  pol;
  logic [2:0]  vsrc;
  logic [1:0]  magsel;
  logic [1:0]  csrc;
  logic [2:0]  edit_grp;
  dep_mag_t    i_thr_g [0:7];
  dep_mag_t    u_thr_g [0:7];
  logic [2:0]  gnd_g   [0:7];
  logic [1:0]  mcd_g   [0:7];
  dep_ang_t    half_g  [0:7];
  dep_ang_t    offs_g  [0:7];
  dep_ang_t    blind_g [0:7];
  dep_ang_t    bord_g  [0:7];
  logic [3:0]  irq_st;
  logic [3:0]  irq_en;
  logic [3:0]  irq_clr;
  logic [3:0]  irq_ev;
  logic [3:0]  next_irq_st;

  logic        acc;
  logic        done;
  logic        wr;
  logic [31:0] rd;
  logic        rd_ok;

  dep_mag_t    cur_mag;
  dep_mag_t    cur_ang;
  dep_mag_t    volt_mag;
  dep_mag_t    volt_ang;
  logic [1:0]  volt_used;
  dep_mag_t    i_thr;
  dep_mag_t    u_thr;
  logic [2:0]  gnd;
  logic [1:0]  multi_criteria_discrimination;
  dep_ang_t    half;
  dep_ang_t    offs;
  dep_ang_t    blind;
  dep_ang_t    bord;
  logic [23:0] i_x100;
  logic [23:0] i_thr97;
  logic [23:0] u_x100;
  logic [23:0] u_thr97;
  logic        i_pick;
  logic        u_pick;
  logic        next_i_pick;
  logic        next_u_pick;
  logic        sq_ok;
  dep_ang_t    diff_raw;
  dep_ang_t    diff;
  dep_ang_t    gdev;
  logic        ue_hit;
  logic        co_hit;
  logic        gr_hit;
  logic        ue_b;
  logic        co_b;
  logic        ang_ok;
  logic [1:0]  kind;
  logic        next_pick;

  logic        blk_s1;
  logic        blk_s2;
  logic        blk_q;
  logic        pick_q;
  logic [1:0]  kind_q;
  logic        sq_q;
  dep_ang_t    diff_q;
  logic [2:0]  next_status;
  logic        next_start;
  logic        next_trip;
  logic        next_blocked;

  function automatic dep_ang_t wrap(input dep_ang_t x);
    dep_ang_t y;
    y = x;
    if (x >= DEG180)
      y = x - DEG360;
    else if (x < -DEG180)
      y = x + DEG360;
    return y;
  endfunction

  function automatic dep_ang_t absv(input dep_ang_t x);
    return (x < 0) ? -x : x;
  endfunction

  // apb: one wait state, so prdata and pslverr come from flops
  assign acc  = psel & penable & ~pready;
  assign done = psel & penable & pready;
  assign wr   = done & pwrite;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc & ~rd_ok;
      prdata  <= (acc & ~pwrite) ? rd : 32'h0000_0000;
    end
  end

  // static selections live apart from the group arrays
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      force_code <= `DEP_RST_FORCE;
      force_en   <= 1'b0;
      pol        <= `DEP_RST_POL;
      vsrc       <= `DEP_RST_VSRC;
      magsel     <= `DEP_RST_MAG;
      csrc       <= `DEP_RST_CSRC;
      edit_grp   <= 3'h0;
      irq_en     <= 4'h0;
    end
    else if (wr)
    begin
      if (paddr == `DEP_OFF_GENERAL)
      begin
        force_code <= pwdata[`DEP_GEN_FORCE];
        force_en   <= pwdata[`DEP_GEN_FEN];
        pol        <= pwdata[`DEP_GEN_POL];
        vsrc       <= pwdata[`DEP_GEN_VSRC];
        magsel     <= pwdata[`DEP_GEN_MAG];
        csrc       <= pwdata[`DEP_GEN_CSRC];
      end
      if (paddr == `DEP_OFF_EDIT)
        edit_grp <= pwdata[2:0];
      if (paddr == `DEP_OFF_IRQ_EN)
        irq_en <= pwdata[3:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : grp
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          i_thr_g[g] <= `DEP_RST_ITHR;
          u_thr_g[g] <= `DEP_RST_UTHR;
          gnd_g[g]   <= `DEP_RST_GND;
          mcd_g[g]   <= `DEP_RST_MCD;
          half_g[g]  <= `DEP_RST_HALF;
          offs_g[g]  <= `DEP_RST_OFFS;
          blind_g[g] <= `DEP_RST_BLIND;
          bord_g[g]  <= `DEP_RST_BORDER;
        end
        else if (wr && edit_grp == 3'(g))
        begin
          case (paddr)
            `DEP_OFF_ITHR:   i_thr_g[g] <= pwdata[15:0];
            `DEP_OFF_UTHR:   u_thr_g[g] <= pwdata[15:0];
            `DEP_OFF_MODE:
            begin
              gnd_g[g] <= pwdata[`DEP_MODE_GND];
              mcd_g[g] <= pwdata[`DEP_MODE_MCD];
            end
            `DEP_OFF_HALF:   half_g[g]  <= pwdata[15:0];
            `DEP_OFF_OFFS:   offs_g[g]  <= pwdata[15:0];
            `DEP_OFF_BLIND:  blind_g[g] <= pwdata[15:0];
            `DEP_OFF_BORDER: bord_g[g]  <= pwdata[15:0];
            default: ;
          endcase
        end
      end
    end
  endgenerate

  always_comb
  begin
    rd    = 32'h0000_0000;
    rd_ok = 1'b1;
    case (paddr)
      `DEP_OFF_GENERAL: rd = {19'h0, csrc, magsel, vsrc, pol, force_en, force_code};
      `DEP_OFF_EDIT:    rd = {29'h0, edit_grp};
      `DEP_OFF_ITHR:    rd = {16'h0, i_thr_g[edit_grp]};
      `DEP_OFF_UTHR:    rd = {16'h0, u_thr_g[edit_grp]};
      `DEP_OFF_MODE:    rd = {26'h0, mcd_g[edit_grp], 1'b0, gnd_g[edit_grp]};
      `DEP_OFF_HALF:    rd = {16'h0, half_g[edit_grp]};
      `DEP_OFF_OFFS:    rd = {16'h0, offs_g[edit_grp]};
      `DEP_OFF_BLIND:   rd = {16'h0, blind_g[edit_grp]};
      `DEP_OFF_BORDER:  rd = {16'h0, bord_g[edit_grp]};
      `DEP_OFF_STATUS:
        rd = {22'h0, volt_used, sq_q, blocked, trip, start, pick_q, stage_status};
      `DEP_OFF_IRQ_ST:  rd = {28'h0, irq_st};
      `DEP_OFF_IRQ_EN:  rd = {28'h0, irq_en};
      `DEP_OFF_IRQ_CLR: rd = 32'h0000_0000;
      `DEP_OFF_ANGLE:   rd = {16'h0, diff_q};
      default:          rd_ok = 1'b0;
    endcase
  end

  // settings of the group chosen by group_sel; static ones stay put
  assign i_thr = i_thr_g[group_sel];
  assign u_thr = u_thr_g[group_sel];
  assign gnd   = gnd_g[group_sel];
  assign multi_criteria_discrimination   = mcd_g[group_sel];
  assign half  = half_g[group_sel];
  assign offs  = offs_g[group_sel];
  assign blind = blind_g[group_sel];
  assign bord  = bord_g[group_sel];

  always_comb
  begin
    cur_mag = i_calc;
    cur_ang = ang_calc;
    case (csrc)
      DEP_CSRC_COARSE:
      begin
        cur_ang = ang_coarse;
        case (magsel)
          DEP_MAG_TRUE_RMS_MAGNITUDE: cur_mag = i_coarse_true_rms_magnitude;
          DEP_MAG_PP:   cur_mag = i_coarse_pp;
          default:      cur_mag = i_coarse_rms;
        endcase
      end
      DEP_CSRC_SENS:
      begin
        cur_ang = ang_sens;
        case (magsel)
          DEP_MAG_TRUE_RMS_MAGNITUDE: cur_mag = i_sens_true_rms_magnitude;
          DEP_MAG_PP:   cur_mag = i_sens_pp;
          default:      cur_mag = i_sens_rms;
        endcase
      end
      default: ;
    endcase
  end

  // volt_used: 0 none, 1 calculated, 2 channel a, 3 channel b
  always_comb
  begin
    volt_mag  = 16'h0000;
    volt_ang  = 16'h0000;
    volt_used = 2'h0;
    case (vsrc)
      DEP_VSRC_CALC:
      begin
        volt_mag  = u_calc;
        volt_ang  = uang_calc;
        volt_used = 2'h1;
      end
      DEP_VSRC_A:
      begin
        volt_mag  = u_chan_a;
        volt_ang  = uang_a;
        volt_used = 2'h2;
      end
      DEP_VSRC_B:
      begin
        volt_mag  = u_chan_b;
        volt_ang  = uang_b;
        volt_used = 2'h3;
      end
      default:
      begin
        if (u_calc_ok)
        begin
          volt_mag  = u_calc;
          volt_ang  = uang_calc;
          volt_used = 2'h1;
        end
      end
    endcase
  end

  assign i_x100  = 24'(cur_mag) * `DEP_RATIO_BASE;
  assign i_thr97 = 24'(i_thr) * `DEP_RESET_RATIO;
  assign u_x100  = 24'(volt_mag) * `DEP_RATIO_BASE;
  assign u_thr97 = 24'(u_thr) * `DEP_RESET_RATIO;
  assign next_i_pick = i_pick ? (i_x100 >= i_thr97) : (cur_mag > i_thr);
  assign next_u_pick = u_pick ? (u_x100 >= u_thr97) : (volt_mag > u_thr);
  // below one percent of nominal the angle is noise
  assign sq_ok = (i_x100 >= `DEP_I_NOMINAL) && (u_x100 >= `DEP_U_NOMINAL);

  // inverted polarity turns the reference half a turn
  assign diff_raw = dep_ang_t'(cur_ang) - dep_ang_t'(volt_ang)
                  - ((pol == DEP_POL_INV) ? DEG180 : 16'sh0000);
  assign diff = wrap(diff_raw);
  assign gdev = wrap(diff - offs);

  assign ue_hit = absv(diff + DEG90) < DEG90;
  assign co_hit = (absv(diff) >= DEG90) && ((diff >= 0) || (diff <= -DEG180 - blind));
  assign gr_hit = absv(gdev) <= half;
  assign ue_b   = (diff <= -bord) && (diff > -DEG180);
  assign co_b   = !ue_b && co_hit && ((multi_criteria_discrimination != DEP_MCD_USED) || mcd_fault);

  // kind: 0 plain, 1 unearthed, 2 compensated
  always_comb
  begin
    case (gnd)
      DEP_GND_COMP:
      begin
        ang_ok = co_hit;
        kind   = 2'h2;
      end
      DEP_GND_GROUND:
      begin
        ang_ok = gr_hit;
        kind   = 2'h0;
      end
      DEP_GND_BROAD:
      begin
        ang_ok = ue_b | co_b;
        kind   = ue_b ? 2'h1 : 2'h2;
      end
      default:
      begin
        ang_ok = ue_hit;
        kind   = 2'h1;
      end
    endcase
  end

  assign next_pick = next_i_pick & next_u_pick & sq_ok & ang_ok & (volt_used != 2'h0);

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
    end
    else
    begin
      blk_s1 <= block_pin;
      blk_s2 <= blk_s1;
    end
  end

  // everything is latched on an update and held between updates
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      i_pick <= 1'b0;
      u_pick <= 1'b0;
      pick_q <= 1'b0;
      blk_q  <= 1'b0;
      kind_q <= 2'h0;
      sq_q   <= 1'b0;
      diff_q <= 16'sh0000;
    end
    else if (meas_valid)
    begin
      i_pick <= next_i_pick;
      u_pick <= next_u_pick;
      pick_q <= next_pick;
      blk_q  <= blk_s2;
      kind_q <= kind;
      sq_q   <= sq_ok;
      diff_q <= diff;
    end
  end

  // instant operation: trip comes with start
  always_comb
  begin
    next_status = DEP_ST_NORMAL;
    if (force_en)
      next_status = force_code;
    else if (blk_q)
      next_status = DEP_ST_BLOCKED;
    else if (pick_q)
      case (kind_q)
        2'h1:    next_status = DEP_ST_UE_TRIP;
        2'h2:    next_status = DEP_ST_CO_TRIP;
        default: next_status = DEP_ST_TRIP;
      endcase
    next_trip    = (next_status == DEP_ST_TRIP) || (next_status == DEP_ST_UE_TRIP)
                || (next_status == DEP_ST_CO_TRIP);
    next_start   = next_trip || (next_status == DEP_ST_START)
                || (next_status == DEP_ST_UE_START) || (next_status == DEP_ST_CO_START);
    next_blocked = (next_status == DEP_ST_BLOCKED);
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      stage_status <= DEP_ST_NORMAL;
      start        <= 1'b0;
      trip         <= 1'b0;
      blocked      <= 1'b0;
      pickup       <= 1'b0;
    end
    else
    begin
      stage_status <= next_status;
      start        <= next_start;
      trip         <= next_trip;
      blocked      <= next_blocked;
      pickup       <= pick_q;
    end
  end

  // event bits: start rise, trip rise, blocked rise, start fall
  assign irq_ev  = {~next_start & start, next_blocked & ~blocked,
                    next_trip & ~trip, next_start & ~start};
  assign irq_clr = (wr && paddr == `DEP_OFF_IRQ_CLR) ? pwdata[3:0] : 4'h0;
  // a new event outweighs a clear in the same cycle
  assign next_irq_st = (irq_st & ~irq_clr) | irq_ev;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irq_st <= 4'h0;
      irq    <= 1'b0;
    end
    else
    begin
      irq_st <= next_irq_st;
      irq    <= |(next_irq_st & irq_en);
    end
  end

  property p_force;
    @(posedge clock) disable iff (reset)
    force_en |=> stage_status == $past(force_code);
  endproperty
  a_force: assert property (p_force) else $error("forced code not shown");

  property p_vsrc;
    @(posedge clock) disable iff (reset)
    vsrc == DEP_VSRC_B |-> volt_mag == u_chan_b && volt_used == 2'h3;
  endproperty
  a_vsrc: assert property (p_vsrc) else $error("voltage channel b not used");

  property p_csrc;
    @(posedge clock) disable iff (reset)
    csrc == DEP_CSRC_CALC && magsel == DEP_MAG_PP |-> cur_mag == i_calc;
  endproperty
  a_csrc: assert property (p_csrc) else $error("calculated current not used");

  property p_release;
    @(posedge clock) disable iff (reset)
    meas_valid && i_pick && i_x100 < i_thr97 |=> !i_pick;
  endproperty
  a_release: assert property (p_release) else $error("no release below ratio");

  property p_set;
    @(posedge clock) disable iff (reset)
    meas_valid && cur_mag > i_thr |=> i_pick ##1 pickup == $past(pick_q);
  endproperty
  a_set: assert property (p_set) else $error("current pick-up missed");

  property p_volt;
    @(posedge clock) disable iff (reset)
    $rose(pick_q) |-> $past(next_u_pick) && $past(ang_ok) && $past(sq_ok);
  endproperty
  a_volt: assert property (p_volt) else $error("pick-up without voltage or angle");

  property p_unearth;
    @(posedge clock) disable iff (reset)
    gnd == DEP_GND_UNEARTH && diff == -DEG90 |-> ang_ok && kind == 2'h1;
  endproperty
  a_unearth: assert property (p_unearth) else $error("lagging current not forward");

  property p_ground;
    @(posedge clock) disable iff (reset)
    gnd == DEP_GND_GROUND && absv(wrap(diff - offs)) > half |-> !ang_ok;
  endproperty
  a_ground: assert property (p_ground) else $error("angle outside grounded area");

  property p_block;
    @(posedge clock) disable iff (reset)
    blk_q && !force_en |=> !start && blocked;
  endproperty
  a_block: assert property (p_block) else $error("start while blocked");

  property p_hold;
    @(posedge clock) disable iff (reset)
    $changed(start) && !$past(force_en) && !$past(force_en, 2) |-> $past(meas_valid, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("start moved between updates");

endmodule
`default_nettype wire

/* File: dep_params.svh */
/*
  dep_params.svh: offsets, field positions, reset values and fixed ratios
  of the directional residual stage. Assumes APB byte addresses on 8 bits.
*/
`ifndef DEP_PARAMS_SVH
`define DEP_PARAMS_SVH

`define DEP_OFF_GENERAL  8'h00
`define DEP_OFF_EDIT     8'h04
`define DEP_OFF_ITHR     8'h08
`define DEP_OFF_UTHR     8'h0c
`define DEP_OFF_MODE     8'h10
`define DEP_OFF_HALF     8'h14
`define DEP_OFF_OFFS     8'h18
`define DEP_OFF_BLIND    8'h1c
`define DEP_OFF_BORDER   8'h20
`define DEP_OFF_STATUS   8'h24
`define DEP_OFF_IRQ_ST   8'h28
`define DEP_OFF_IRQ_EN   8'h2c
`define DEP_OFF_IRQ_CLR  8'h30
`define DEP_OFF_ANGLE    8'h34

`define DEP_GEN_FORCE    2:0
`define DEP_GEN_FEN      3
`define DEP_GEN_POL      5:4
`define DEP_GEN_VSRC     8:6
`define DEP_GEN_MAG      10:9
`define DEP_GEN_CSRC     12:11
`define DEP_MODE_GND     2:0
`define DEP_MODE_MCD     5:4

`define DEP_RST_FORCE    3'h0
`define DEP_RST_POL      2'h1
`define DEP_RST_VSRC     3'h1
`define DEP_RST_MAG      2'h1
`define DEP_RST_CSRC     2'h1
`define DEP_RST_ITHR     16'h04b0
`define DEP_RST_UTHR     16'h07d0
`define DEP_RST_GND      3'h1
`define DEP_RST_MCD      2'h1
`define DEP_RST_HALF     16'h0370
`define DEP_RST_OFFS     16'h0000
`define DEP_RST_BLIND    16'hfc7c
`define DEP_RST_BORDER   16'h01c2

`define DEP_RESET_RATIO  24'h000061
`define DEP_RATIO_BASE   24'h000064
`define DEP_I_NOMINAL    24'h0003e8
`define DEP_U_NOMINAL    24'h002710
`define DEP_DEG90        16'h0384
`define DEP_DEG180       16'h0708
`define DEP_DEG360       16'h0e10

`endif

/* File: dep_pkg.sv */
/*
  dep_pkg: types and setting encodings of the directional residual stage.
  Assumes nothing of its surroundings.
*/
package dep_pkg;
  typedef logic [15:0]        dep_mag_t;
  typedef logic signed [15:0] dep_ang_t;
  typedef enum logic [2:0] {
    DEP_ST_NORMAL, DEP_ST_START, DEP_ST_TRIP, DEP_ST_BLOCKED,
    DEP_ST_UE_START, DEP_ST_UE_TRIP, DEP_ST_CO_START, DEP_ST_CO_TRIP
  } dep_status_t;
  typedef enum logic [2:0] {
    DEP_GND_UNEARTH = 3'h1, DEP_GND_COMP = 3'h2,
    DEP_GND_GROUND = 3'h3, DEP_GND_BROAD = 3'h4
  } dep_gnd_t;
  typedef enum logic [1:0] {
    DEP_CSRC_COARSE = 2'h1, DEP_CSRC_SENS = 2'h2, DEP_CSRC_CALC = 2'h3
  } dep_csrc_t;
  typedef enum logic [1:0] {
    DEP_MAG_RMS = 2'h1, DEP_MAG_TRUE_RMS_MAGNITUDE = 2'h2, DEP_MAG_PP = 2'h3
  } dep_magsel_t;
  typedef enum logic [2:0] {
    DEP_VSRC_AUTO = 3'h1, DEP_VSRC_CALC = 3'h2,
    DEP_VSRC_A = 3'h3, DEP_VSRC_B = 3'h4
  } dep_vsrc_t;
  typedef enum logic [1:0] {DEP_POL_DIRECT = 2'h1, DEP_POL_INV = 2'h2} dep_pol_t;
  typedef enum logic [1:0] {DEP_MCD_OFF = 2'h1, DEP_MCD_USED = 2'h2} dep_mcd_t;
endpackage

/* File: dep_meas_model.sv */
/*
  dep_meas_model: pre-processed residual channels feeding the stage.
  Assumes the stage clock; the bench sets values, routing and pulse gap.
*/
`timescale 1ns/1ps
`default_nettype none
module dep_meas_model
  import dep_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [2:0] gap,
  input  wire logic [2:0] csel,
  input  wire logic [1:0] vsel,
  input  wire dep_mag_t   cur,
  input  wire dep_mag_t   volt,
  output var  logic       meas_valid,
  output var  dep_mag_t   ic [0:6],
  output var  dep_mag_t   uc [0:2]
);
  logic [2:0] cnt;

  always_ff @(posedge clock)
  begin
    cnt        <= (reset || cnt >= gap) ? 3'h0 : cnt + 3'h1;
    meas_valid <= !reset && cnt == gap;
  end

  // unrouted channels carry a small live value, so a wrong pick shows
  always_comb
  begin
    for (int k = 0; k < 7; k++)
      ic[k] = (3'(k) == csel) ? cur : cur >> 5;
    for (int k = 0; k < 3; k++)
      uc[k] = (2'(k) == vsel) ? volt : volt >> 5;
  end
endmodule
`default_nettype wire

/* File: tb.sv */
/*
  tb: self-checking bench of the directional residual stage.
  Assumes dep_stage and dep_meas_model on one 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import dep_pkg::*;
;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, mv, pickup, start, trip, blocked, irq, er;
  logic        blk = 1'b0, ucok = 1'b1, mf = 1'b0;
  logic [2:0]  st, gap = 3'h1, csel = 3'h0, grp = 3'h0;
  logic [1:0]  vsel = 2'h0;
  dep_mag_t    cur = 16'h0, cang = 16'h0, vang = 16'h0, volt = 16'd5000, m;
  dep_mag_t    ic [0:6];
  dep_mag_t    uc [0:2];
  int          bad_count = 0, samples_checked = 0, d;
  logic [7:0]  ra [10] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
                           8'h30, 8'h3c};
  logic [31:0] rv [10] = '{32'h0a50, 32'h04b0, 32'h07d0, 32'h11, 32'h0370, 32'h0,
                           32'hfc7c, 32'h01c2, 32'h0, 32'h0};
  logic [7:0]  mm [9] = '{8'h12, 8'h12, 8'h12, 8'h14, 8'h14, 8'h24, 8'h13, 8'h13, 8'h13};
  int          md [9] = '{1700, -1000, -300, -1000, 1700, 1700, 900, 1780, 1790};
  logic [2:0]  ms [9] = '{3'h7, 3'h7, 3'h0, 3'h5, 3'h7, 3'h0, 3'h2, 3'h2, 3'h0};

  dep_meas_model mdl (.clock(clock), .reset(reset), .gap(gap), .csel(csel), .vsel(vsel),
    .cur(cur), .volt(volt), .meas_valid(mv), .ic(ic), .uc(uc));

  dep_stage dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_valid(mv),
    .i_coarse_rms(ic[0]), .i_coarse_true_rms_magnitude(ic[1]), .i_coarse_pp(ic[2]),
    .i_sens_rms(ic[3]), .i_sens_true_rms_magnitude(ic[4]), .i_sens_pp(ic[5]), .i_calc(ic[6]),
    .ang_coarse(cang), .ang_sens(cang), .ang_calc(cang), .u_calc(uc[0]),
    .u_chan_a(uc[1]), .u_chan_b(uc[2]), .u_calc_ok(ucok), .uang_calc(vang),
    .uang_a(vang), .uang_b(vang), .mcd_fault(mf), .group_sel(grp),
    .block_pin(blk), .start(start), .trip(trip), .blocked(blocked),
    .stage_status(st), .pickup(pickup), .irq(irq));

  initial
  begin
    forever #12.5 clock = ~clock;
  end

  task automatic test_done();
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // entered right after a rising edge; holds the request until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic [31:0] g(input int cs, mg, vs, po, fe, fc);
    return {19'h0, 2'(cs), 2'(mg), 3'(vs), 2'(po), 1'(fe), 3'(fc)};
  endfunction

  function automatic logic xp(input int m, t, input logic w);
    return m > t || w && m * 100 >= t * 97;
  endfunction

  function automatic logic [6:0] xo(input logic p, b, input logic [2:0] s);
    return b ? {p, 3'b001, 3'h3} : (p ? {3'b111, 1'b0, s} : 7'h0);
  endfunction

  // three pulses so the two-flop block path has caught up too
  task automatic meas(input dep_mag_t c, input int a, input logic [6:0] e, input string n);
    dep_mag_t va;
    va = dep_mag_t'($urandom_range(3599));
    cur <= c;
    vang <= va;
    cang <= dep_mag_t'((int'(va) + 3600 + a) % 3600);
    gap <= 3'($urandom_range(4));
    repeat (3) do @(posedge clock); while (mv !== 1'b1);
    repeat (2) @(posedge clock);
    #1 chk(n, {25'h0, e}, {25'h0, pickup, start, trip, blocked, st});
    @(posedge clock);
  endtask

  initial
  begin
    logic pk, ip;
    d = $urandom(32'hddc1e884);
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rv[i], rd);
    end
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, 8'h2c, 32'h1);
    ip = 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      m = dep_mag_t'($urandom_range(1250, 1100));
      d = int'($urandom_range(3400)) - 1700;
      // current hysteresis runs on its own, whatever the angle does
      ip = xp(int'(m), 1200, ip);
      pk = ip && d > -1800 && d < 0;
      meas(m, d, xo(pk, 1'b0, 3'h5), "unearthed");
    end
    meas(16'd1163, -900, 7'h0, "release");
    apb(1'b1, 8'h30, 32'hf);
    meas(16'd1200, -900, 7'h0, "at threshold");
    meas(16'd1201, -900, xo(1'b1, 1'b0, 3'h5), "above threshold");
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b0, 8'h28, 32'h0);
    chk("irq status", 32'h3, rd);
    apb(1'b1, 8'h30, 32'hf);
    chk("irq cleared", 32'h0, {31'h0, irq});
    meas(16'd1164, -900, xo(1'b1, 1'b0, 3'h5), "hold");
    meas(16'd1163, -900, 7'h0, "drop");
    apb(1'b0, 8'h28, 32'h0);
    chk("start fall", 32'h8, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h08, 32'h5);
    meas(16'd9, -900, 7'h0, "squelch");
    meas(16'd10, -900, xo(1'b1, 1'b0, 3'h5), "squelch edge");
    apb(1'b1, 8'h08, 32'd1200);
    blk <= 1'b1;
    meas(16'd1500, -900, xo(1'b1, 1'b1, 3'h0), "blocked");
    blk <= 1'b0;
    apb(1'b1, 8'h18, 32'd900);
    foreach (mm[i])
    begin
      apb(1'b1, 8'h10, {24'h0, mm[i]});
      meas(16'd1500, md[i], xo(ms[i] != 0, 1'b0, ms[i]), "mode");
    end
    mf <= 1'b1;
    apb(1'b1, 8'h10, 32'h24);
    meas(16'd1500, 1700, xo(1'b1, 1'b0, 3'h7), "mcd fault");
    mf <= 1'b0;
    apb(1'b1, 8'h10, 32'h11);
    for (int i = 0; i < 7; i++)
      for (int s = 0; s < 7; s++)
      begin
        csel <= 3'(i);
        d = s < 6 ? s % 3 + 1 : int'($urandom_range(3, 1));
        apb(1'b1, 8'h00, g(s / 3 + 1, d, 1, 1, 0, 0));
        meas(16'd1500, -900, xo(i == s, 1'b0, 3'h5), "current source");
      end
    csel <= 3'h0;
    for (int v = 1; v < 5; v++)
      for (int j = 0; j < 3; j++)
      begin
        vsel <= 2'(j);
        d = (v + j) % 2 ? 900 : -900;
        apb(1'b1, 8'h00, g(1, 1, v, 1 + (v + j) % 2, 0, 0));
        pk = v < 3 ? j == 0 : j == v - 2;
        meas(16'd1500, d, xo(pk, 1'b0, 3'h5), "voltage source");
      end
    ucok <= 1'b0;
    vsel <= 2'h0;
    apb(1'b1, 8'h00, g(1, 1, 1, 1, 0, 0));
    meas(16'd1500, -900, 7'h0, "no voltage");
    ucok <= 1'b1;
    grp <= 3'h3;
    apb(1'b0, 8'h00, 32'h0);
    chk("static general", g(1, 1, 1, 1, 0, 0), rd);
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, 8'h00, g(1, 1, 1, 1, 1, c));
      @(posedge clock);
      #1 chk("forced", {26'h0, c != 0 && c != 3, c == 2 || c == 5 || c == 7, c == 3, 3'(c)},
        {26'h0, start, trip, blocked, st});
      @(posedge clock);
    end
    test_done();
  end

  initial
  begin
    repeat (40000) @(posedge clock);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
